/* pkg/arwm_pkg.sv */
package arwm_pkg;
  localparam logic [7:0] ADDR_RES_LOW  = 8'hbd;
  localparam logic [7:0] ADDR_RES_HIGH = 8'hbe;
  localparam logic [7:0] ADDR_LT_LOW   = 8'hc5;
  localparam logic [7:0] ADDR_LT_HIGH  = 8'hc6;
  localparam logic [7:0] ADDR_GT_LOW   = 8'hc3;
  localparam logic [7:0] ADDR_GT_HIGH  = 8'hc4;
  localparam logic [7:0] ADDR_MUX_SEL  = 8'hbb;
  localparam logic [7:0] ADDR_REF_CTRL = 8'hd1;

  localparam logic [7:0] RST_RES_LOW   = 8'h00;
  localparam logic [7:0] RST_RES_HIGH  = 8'h00;
  localparam logic [7:0] RST_LT_LOW    = 8'h00;
  localparam logic [7:0] RST_LT_HIGH   = 8'h00;
  localparam logic [7:0] RST_GT_LOW    = 8'hff;
  localparam logic [7:0] RST_GT_HIGH   = 8'hff;
  localparam logic [7:0] RST_MUX_SEL   = 8'h1f;
  localparam logic [7:0] RST_REF_CTRL  = 8'h18;

  // Writable bits; the rest read as zero
  localparam logic [7:0] MASK_MUX_SEL  = 8'h1f;
  localparam logic [7:0] MASK_REF_CTRL = 8'hbc;

  localparam int REF_LEVEL_BIT   = 7;
  localparam int REF_GND_SEL_BIT = 5;
  localparam int REF_SRC_MSB     = 4;
  localparam int REF_SRC_LSB     = 3;
  localparam int REF_TEMP_EN_BIT = 2;

  localparam logic [4:0] MUX_TEMP   = 5'h10;
  localparam logic [4:0] MUX_LDO    = 5'h11;
  localparam logic [4:0] MUX_VDD    = 5'h12;
  localparam logic [4:0] MUX_GND    = 5'h13;

  typedef struct packed {
    logic [15:0] ext_sel;
    logic        temp_sel;
    logic        ldo_sel;
    logic        vdd_sel;
    logic        gnd_sel;
  } arwm_mux_s;

  typedef struct packed {
    logic       internal_reference_level;
    logic       ground_reference_select;
    logic [1:0] reference_source_select;
    logic [3:0] ref_route;
    logic       temp_sensor_enable;
  } arwm_ref_s;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } arwm_sfr_s;
endpackage

/* hw/arwm_regs.sv */
`timescale 1ns/1ps
module arwm_regs (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // Special-function-register access
  input  wire arwm_pkg::arwm_sfr_s sfr,
  output logic [7:0]               sfr_rdata,
  // Conversion engine
  input  wire logic                conv_done,
  input  wire logic [15:0]         conv_data,
  input  wire logic [2:0]          result_format_select,
  input  wire logic                conversion_sync_bit,
  // Window compare
  input  wire logic                window_flag_clr,
  output logic                     window_flag,
  // Analog controls
  output arwm_pkg::arwm_mux_s      analog_input_mux,
  output arwm_pkg::arwm_ref_s      reference_control
);

  logic [15:0]         acc_q, acc_d;
  logic [7:0]          gt_hi_q, gt_hi_d, gt_lo_q, gt_lo_d;
  logic [7:0]          lt_hi_q, lt_hi_d, lt_lo_q, lt_lo_d;
  logic [7:0]          mux_q, mux_d, ref_q, ref_d;
  logic [7:0]          rdata_q, rdata_d;
  logic                win_q, win_d;
  arwm_pkg::arwm_mux_s amux_q, amux_d;
  arwm_pkg::arwm_ref_s aref_q, aref_d;
  logic [15:0]         fmt_acc, fmt_conv, gt_thr, lt_thr;
  logic                wr_lo, wr_hi;

  function automatic logic win_hit(input logic [15:0] x, input logic [15:0] gt,
                                   input logic [15:0] lt);
    if (lt > gt) begin
      win_hit = (x > gt) && (x < lt);
    end else begin
      win_hit = (x > gt) || (x < lt);
    end
  endfunction

  function automatic arwm_pkg::arwm_mux_s mux_dec(input logic [4:0] code);
    mux_dec = '0;
    if (code[4] == 1'b0) begin
      mux_dec.ext_sel = 16'h0001 << code[3:0];
    end else begin
      case (code)
        arwm_pkg::MUX_TEMP: mux_dec.temp_sel = 1'b1;
        arwm_pkg::MUX_LDO:  mux_dec.ldo_sel  = 1'b1;
        arwm_pkg::MUX_VDD:  mux_dec.vdd_sel  = 1'b1;
        arwm_pkg::MUX_GND:  mux_dec.gnd_sel  = 1'b1;
        default:            mux_dec = '0;
      endcase
    end
  endfunction

  // Format shifts right, filling the top with zeros
  assign fmt_acc  = acc_q >> result_format_select;
  assign fmt_conv = conv_data >> result_format_select;
  assign gt_thr   = {gt_hi_q, gt_lo_q};
  assign lt_thr   = {lt_hi_q, lt_lo_q};
  assign wr_lo    = sfr.wr && (sfr.addr == arwm_pkg::ADDR_RES_LOW);
  assign wr_hi    = sfr.wr && (sfr.addr == arwm_pkg::ADDR_RES_HIGH);

  always_comb begin
    acc_d   = acc_q;
    gt_hi_d = gt_hi_q;
    gt_lo_d = gt_lo_q;
    lt_hi_d = lt_hi_q;
    lt_lo_d = lt_lo_q;
    mux_d   = mux_q;
    ref_d   = ref_q;
    // A conversion result takes priority over a software byte write
    if (conv_done) begin
      acc_d = conv_data;
    end else begin
      if (wr_hi) begin
        acc_d[15:8] = sfr.wdata;
      end
      if (wr_lo) begin
        acc_d[7:0] = sfr.wdata;
      end
    end
    if (sfr.wr) begin
      case (sfr.addr)
        arwm_pkg::ADDR_GT_HIGH:  gt_hi_d = sfr.wdata;
        arwm_pkg::ADDR_GT_LOW:   gt_lo_d = sfr.wdata;
        arwm_pkg::ADDR_LT_HIGH:  lt_hi_d = sfr.wdata;
        arwm_pkg::ADDR_LT_LOW:   lt_lo_d = sfr.wdata;
        arwm_pkg::ADDR_MUX_SEL:  mux_d = sfr.wdata & arwm_pkg::MASK_MUX_SEL;
        arwm_pkg::ADDR_REF_CTRL: ref_d = sfr.wdata & arwm_pkg::MASK_REF_CTRL;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_q   <= {arwm_pkg::RST_RES_HIGH, arwm_pkg::RST_RES_LOW};
      gt_hi_q <= arwm_pkg::RST_GT_HIGH;
      gt_lo_q <= arwm_pkg::RST_GT_LOW;
      lt_hi_q <= arwm_pkg::RST_LT_HIGH;
      lt_lo_q <= arwm_pkg::RST_LT_LOW;
      mux_q   <= arwm_pkg::RST_MUX_SEL;
      ref_q   <= arwm_pkg::RST_REF_CTRL;
    end else begin
      acc_q   <= acc_d;
      gt_hi_q <= gt_hi_d;
      gt_lo_q <= gt_lo_d;
      lt_hi_q <= lt_hi_d;
      lt_lo_q <= lt_lo_d;
      mux_q   <= mux_d;
      ref_q   <= ref_d;
    end
  end

  // Read path
  always_comb begin
    rdata_d = rdata_q;
    if (sfr.rd) begin
      case (sfr.addr)
        arwm_pkg::ADDR_RES_HIGH: rdata_d = fmt_acc[15:8];
        arwm_pkg::ADDR_RES_LOW:  rdata_d = fmt_acc[7:0];
        arwm_pkg::ADDR_GT_HIGH:  rdata_d = gt_hi_q;
        arwm_pkg::ADDR_GT_LOW:   rdata_d = gt_lo_q;
        arwm_pkg::ADDR_LT_HIGH:  rdata_d = lt_hi_q;
        arwm_pkg::ADDR_LT_LOW:   rdata_d = lt_lo_q;
        arwm_pkg::ADDR_MUX_SEL:  rdata_d = mux_q;
        arwm_pkg::ADDR_REF_CTRL: rdata_d = ref_q;
        default:                 rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Window compare
  always_comb begin
    win_d = win_q;
    // Set wins over clear
    if (window_flag_clr) begin
      win_d = 1'b0;
    end
    if (conv_done && win_hit(fmt_conv, gt_thr, lt_thr)) begin
      win_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= 1'b0;
    end else begin
      win_q <= win_d;
    end
  end

  // Analog selects decode the next register values, so they move with them
  always_comb begin
    amux_d = mux_dec(mux_d[4:0]);
    aref_d.internal_reference_level = ref_d[arwm_pkg::REF_LEVEL_BIT];
    aref_d.ground_reference_select  = ref_d[arwm_pkg::REF_GND_SEL_BIT];
    aref_d.reference_source_select  = ref_d[arwm_pkg::REF_SRC_MSB:arwm_pkg::REF_SRC_LSB];
    aref_d.ref_route   = 4'h1 << ref_d[arwm_pkg::REF_SRC_MSB:arwm_pkg::REF_SRC_LSB];
    aref_d.temp_sensor_enable = ref_d[arwm_pkg::REF_TEMP_EN_BIT];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      amux_q <= '0;
      aref_q <= '{internal_reference_level: 1'b0, ground_reference_select: 1'b0,
                  reference_source_select: 2'h3, ref_route: 4'h8,
                  temp_sensor_enable: 1'b0};
    end else begin
      amux_q <= amux_d;
      aref_q <= aref_d;
    end
  end

  assign sfr_rdata         = rdata_q;
  assign window_flag       = win_q;
  assign analog_input_mux  = amux_q;
  assign reference_control = aref_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  rd_high_a: assert property (sfr.rd && sfr.addr == arwm_pkg::ADDR_RES_HIGH
    |=> sfr_rdata == $past(fmt_acc[15:8]))
    else $error("result high byte read wrong");
  rd_low_a: assert property (sfr.rd && sfr.addr == arwm_pkg::ADDR_RES_LOW
    |=> sfr_rdata == $past(fmt_acc[7:0]))
    else $error("result low byte read wrong");
  wr_high_a: assert property (wr_hi && !conv_done
    |=> acc_q[15:8] == $past(sfr.wdata))
    else $error("result high byte write lost");
  wr_low_a: assert property (wr_lo && !conv_done
    |=> acc_q[7:0] == $past(sfr.wdata))
    else $error("result low byte write lost");
  shift_zero_a: assert property (result_format_select != 3'h0
    |-> fmt_acc[15] == 1'b0)
    else $error("shifted result top bit not zero");
  gt_form_a: assert property (sfr.wr && sfr.addr == arwm_pkg::ADDR_GT_HIGH
    |=> gt_thr[15:8] == $past(sfr.wdata))
    else $error("greater-than high byte not placed");
  lt_form_a: assert property (sfr.wr && sfr.addr == arwm_pkg::ADDR_LT_LOW
    |=> lt_thr[7:0] == $past(sfr.wdata))
    else $error("less-than low byte not placed");
  mux_ext_a: assert property (mux_q[4] == 1'b0
    |-> analog_input_mux.ext_sel == (16'h0001 << mux_q[3:0]))
    else $error("external input route wrong");
  mux_int_a: assert property (mux_q[4:0] == arwm_pkg::MUX_GND
    |-> analog_input_mux == 20'h00001)
    else $error("ground route wrong");
  mux_none_a: assert property (mux_q[4:0] >= 5'h14
    |-> analog_input_mux == '0)
    else $error("reserved code routed an input");
  ref_sel_a: assert property (
    reference_control.ref_route == (4'h1 << ref_q[4:3]))
    else $error("reference route wrong");
  temp_en_a: assert property (reference_control.temp_sensor_enable == ref_q[2])
    else $error("temperature sensor enable wrong");
  window_set_a: assert property (conv_done && win_hit(fmt_conv, gt_thr, lt_thr)
    |=> window_flag ##1 (window_flag || $past(window_flag_clr)))
    else $error("window flag not set");

  // Threshold, accumulator and read-path checks
  gt_low_a: assert property (sfr.wr && sfr.addr == arwm_pkg::ADDR_GT_LOW
    |=> gt_thr[7:0] == $past(sfr.wdata))
    else $error("greater-than low byte not placed");
  lt_high_a: assert property (sfr.wr && sfr.addr == arwm_pkg::ADDR_LT_HIGH
    |=> lt_thr[15:8] == $past(sfr.wdata))
    else $error("less-than high byte not placed");
  thr_stable_a: assert property (!sfr.wr
    |=> $stable(gt_thr) && $stable(lt_thr))
    else $error("threshold changed without a write");
  conv_load_a: assert property (conv_done
    |=> acc_q == $past(conv_data))
    else $error("conversion word not loaded");
  shift_read_a: assert property (sfr.rd && sfr.addr == arwm_pkg::ADDR_RES_HIGH
    && result_format_select != 3'h0 |=> sfr_rdata[7] == 1'b0)
    else $error("shifted high byte top bit not zero");
  shift_max_a: assert property (sfr.rd && sfr.addr == arwm_pkg::ADDR_RES_HIGH
    && result_format_select == 3'h7 |=> sfr_rdata[7:1] == 7'h00)
    else $error("fully shifted high byte not zero-filled");
  rd_hold_a: assert property (!sfr.rd
    |=> $stable(sfr_rdata))
    else $error("read data moved without a read");

  // Window flag checks
  window_clear_a: assert property (window_flag_clr && !conv_done
    |=> !window_flag)
    else $error("window flag not cleared");
  window_hold_a: assert property (!window_flag_clr && !conv_done
    |=> window_flag == $past(window_flag))
    else $error("window flag moved without an event");
  set_wins_a: assert property (conv_done && window_flag_clr
    && win_hit(fmt_conv, gt_thr, lt_thr) |=> window_flag)
    else $error("clear beat a window hit");

  // Analog select checks
  mux_temp_a: assert property (mux_q[4:0] == arwm_pkg::MUX_TEMP
    |-> analog_input_mux == 20'h00008)
    else $error("temperature sensor route wrong");
  mux_ldo_a: assert property (mux_q[4:0] == arwm_pkg::MUX_LDO
    |-> analog_input_mux == 20'h00004)
    else $error("regulator route wrong");
  mux_vdd_a: assert property (mux_q[4:0] == arwm_pkg::MUX_VDD
    |-> analog_input_mux == 20'h00002)
    else $error("supply route wrong");
  ext_none_a: assert property (mux_q[4] == 1'b1
    |-> analog_input_mux.ext_sel == 16'h0000)
    else $error("external input routed for an internal code");
  mux_onehot_a: assert property ($onehot0(analog_input_mux))
    else $error("more than one input routed");
  ref_fields_a: assert property (
    reference_control.internal_reference_level == ref_q[7]
    && reference_control.ground_reference_select == ref_q[5]
    && reference_control.reference_source_select == ref_q[4:3])
    else $error("reference fields wrong");

  conv_cov: cover property (conv_done ##1 sfr.rd && sfr.addr == arwm_pkg::ADDR_RES_HIGH);
  win_cov: cover property (conv_done && window_flag_clr ##1 window_flag);
  mux_cov: cover property (sfr.wr && sfr.addr == arwm_pkg::ADDR_MUX_SEL ##1 amux_q.temp_sel);
  sync_cov: cover property (conversion_sync_bit && wr_hi);
  ref_cov: cover property (sfr.wr && sfr.addr == arwm_pkg::ADDR_REF_CTRL
    ##1 reference_control.temp_sensor_enable);

endmodule

/* verification/test_adc_result_window_mux_regs.sv */
`timescale 1ns/1ps
module test_adc_result_window_mux_regs;
  logic                clk_sys;
  logic                rst_n;
  arwm_pkg::arwm_sfr_s sfr;
  logic [7:0]          sfr_rdata;
  logic                conv_done;
  logic [15:0]         conv_data;
  logic [2:0]          result_format_select;
  logic                conversion_sync_bit;
  logic                window_flag_clr;
  logic                window_flag;
  arwm_pkg::arwm_mux_s analog_input_mux;
  arwm_pkg::arwm_ref_s reference_control;
  int                  n_errors;
  int                  num_checks;
  int                  seed;
  logic [7:0]          exp_q[$];
  logic                rd_d;
  logic [15:0]         acc, gt, lt, x;
  logic [7:0]          v;
  logic [7:0]          ra[9] = '{8'hbd, 8'hbe, 8'hc5, 8'hc6, 8'hc3, 8'hc4, 8'hbb, 8'hd1, 8'h00};
  logic [7:0]          rv[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h1f, 8'h18, 8'h00};

  arwm_regs dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .conv_done(conv_done), .conv_data(conv_data),
    .result_format_select(result_format_select), .conversion_sync_bit(conversion_sync_bit),
    .window_flag_clr(window_flag_clr), .window_flag(window_flag),
    .analog_input_mux(analog_input_mux), .reference_control(reference_control));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic final_report();
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_sys);
    sfr.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    exp_q.push_back(e);
    @(posedge clk_sys);
    sfr.rd <= 1'b0;
  endtask

  // Clears the flag, then one conversion; flag is judged the cycle after
  task automatic conv(input logic [15:0] d, input logic [2:0] f);
    @(posedge clk_sys);
    window_flag_clr <= 1'b1;
    result_format_select <= f;
    @(posedge clk_sys);
    window_flag_clr <= 1'b0;
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge clk_sys);
    conv_done <= 1'b0;
    @(negedge clk_sys);
    x = d >> f;
    chk("window_flag", 20'(lt > gt ? (x > gt && x < lt) : (x > gt || x < lt)), 20'(window_flag));
  endtask

  // Read data lands one cycle after the strobe
  always @(posedge clk_sys) rd_d <= sfr.rd;
  always @(negedge clk_sys) begin
    if (rd_d) begin
      if (exp_q.size() == 0) chk("read queue", 20'h1, 20'h0);
      else chk("sfr_rdata", 20'(exp_q.pop_front()), 20'(sfr_rdata));
    end
  end

  initial begin
    repeat (50000) @(posedge clk_sys);
    chk("timeout", 20'h1, 20'h0);
    final_report();
  end

  initial begin
    sfr = '0;
    conv_done = 1'b0;
    conv_data = 16'h0000;
    result_format_select = 3'h0;
    conversion_sync_bit = 1'b0;
    window_flag_clr = 1'b0;
    rst_n = 1'b0;
    rd_d = 1'b0;
    n_errors = 0;
    num_checks = 0;
    seed = $urandom(47);
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk("mux reset", 20'h0, analog_input_mux);
    chk("ref reset", 20'({4'b0011, 4'h8, 1'b0}), 20'(reference_control));
    for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
    acc = 16'($urandom);
    wr(8'hbe, acc[15:8]);
    wr(8'hbd, acc[7:0]);
    for (int f = 0; f < 8; f++) begin
      result_format_select <= 3'(f);
      x = acc >> f;
      rd(8'hbe, x[15:8]);
      rd(8'hbd, x[7:0]);
    end
    for (int k = 0; k < 2; k++) begin
      gt = 16'($urandom);
      lt = 16'($urandom);
      if ((lt > gt) != (k == 0)) {gt, lt} = {lt, gt};
      wr(8'hc4, gt[15:8]);
      wr(8'hc3, gt[7:0]);
      wr(8'hc6, lt[15:8]);
      wr(8'hc5, lt[7:0]);
      rd(8'hc4, gt[15:8]);
      rd(8'hc3, gt[7:0]);
      rd(8'hc6, lt[15:8]);
      rd(8'hc5, lt[7:0]);
      repeat (12) conv(16'($urandom), 3'($urandom));
      rd(8'hbd, x[7:0]);
    end
    // Zero low threshold bytes, then a hit that meets a clear in one cycle
    wr(8'hc3, 8'h00);
    wr(8'hc5, 8'h00);
    wr(8'hc4, 8'h10);
    wr(8'hc6, 8'h20);
    gt = 16'h1000;
    lt = 16'h2000;
    conv(16'h3000, 3'h0);
    @(posedge clk_sys);
    conv_done <= 1'b1;
    conv_data <= 16'h1800;
    window_flag_clr <= 1'b1;
    @(posedge clk_sys);
    conv_done <= 1'b0;
    window_flag_clr <= 1'b0;
    @(negedge clk_sys);
    chk("window set wins", 20'h1, 20'(window_flag));
    rd(8'hbe, 8'h18);
    for (int c = 0; c < 32; c++) begin
      wr(8'hbb, 8'(c));
      @(negedge clk_sys);
      chk("mux", c < 16 ? 20'(1 << (c + 4)) : (c < 20 ? 20'(8 >> (c - 16)) : 20'h0),
          analog_input_mux);
      rd(8'hbb, 8'(c));
    end
    for (int r = 0; r < 32; r++) begin
      v = {r[4], 1'b0, r[3], r[2:1], r[0], 2'b00};
      wr(8'hd1, v);
      @(negedge clk_sys);
      chk("ref", 20'({r[4], r[3], r[2:1], 4'(1 << r[2:1]), r[0]}),
          20'(reference_control));
      rd(8'hd1, v);
    end
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk_sys);
    if (exp_q.size() != 0) chk("queue drain", 20'h0, 20'(exp_q.size()));
    final_report();
  end
endmodule
